/* File: verilog/ccm_consts.svh */
// Offsets, reset values and field positions of the chain-mode block
// Assumes a 32-bit APB slave with word-aligned registers
`ifndef CCM_CONSTS_SVH
`define CCM_CONSTS_SVH
`define CCM_CTRL_OFS     12'h000
`define CCM_STAT_OFS     12'h004
`define CCM_SEL_LSB      0
`define CCM_MODE_BIT     2
`define CCM_STAT_SEN_BIT 2
`define CCM_STAT_SIB_LSB 16
`define CCM_SEL_RST      2'h1
`define CCM_MIN_SEG      32
`endif

/* File: verilog/ccm_pkg.sv */
// Types of the chain-mode block
// Holds its own source codes and field widths; takes nothing from ccm_consts.svh
package ccm_pkg;
   typedef enum logic [1:0] {
      CCM_SRC_SHIFT = 2'b00,
      CCM_SRC_TEST  = 2'b01,
      CCM_SRC_TCK   = 2'b10
   } ccm_src_t;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ccm_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } ccm_apb_rsp_t;
endpackage

/* File: verilog/ccm_ctrl_chain.sv */
// Controller chain scan access for the built-in test logic
// Assumes all pins and tck are asynchronous to clk and are slower than clk/4
//
// Function
// - The runtime clock selector chooses among shift clock source, test clock and tck.
// - After reset the selector picks the test clock.
// - With controller chain mode set, the runtime clock follows tck.
// - The chain shift clock is fixed by a parameter, tck or the test clock.
// - With segments separate, each instrument has its own chain scan input, scan output and enable-steered muxes.
// - With chain inputs tied low the chain stays idle and its outputs unused.
// - Chain shift enable is the AND of the chain enable and the scan enable.
// - Flops outside the access network are muxed into it to form one shift path.
// - Segments are separate by default, or joined into one chain when so built.
// - Segment length is bounded by a maximum that is unlimited or at least 32.
// - A set insertion bit puts its data register in the path, a clear one bypasses it.
// - Insertion bits are clocked by tck, or by the test clock during a chain shift when CCM_CLK_TCK is clear.
// - The top insertion bit is enabled by the instruction, each child by its parent.
`timescale 1ns/1ns
`include "ccm_consts.svh"
module ccm_ctrl_chain
   import ccm_pkg::*;
#(
   parameter int NSEG          = 3,
   parameter int DR_LEN        = 8,
   parameter int EXT_LEN       = 4,
   parameter int MAX_SEG_LEN   = 0,
   parameter bit SEG_PER_INSTR = 1'b1,
   parameter bit CCM_CLK_TCK   = 1'b1
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      srst,
   // Register bus
   input  wire ccm_apb_req_t              apb_req,
   output ccm_apb_rsp_t                   apb_rsp,
   // Clock sources
   input  wire logic                      tck,
   input  wire logic                      shift_clock_src,
   output logic                           edt_lbist_clk_en,
   // Access network
   input  wire logic                      lbist_tap_instruction,
   input  wire logic                      shift_dr,
   input  wire logic                      tdi,
   output logic                           tdo,
   // Chain scan
   input  wire logic                      ccm_en,
   input  wire logic                      scan_en,
   input  wire logic [NSEG-1:0]           ccm_scan_in,
   output logic      [NSEG-1:0]           ccm_scan_out,
   // Functional flops
   input  wire logic [NSEG*EXT_LEN-1:0]   func_d,
   output logic      [NSEG*EXT_LEN-1:0]   func_q
);
   localparam int SL    = 1 + DR_LEN + EXT_LEN;
   localparam int PW    = 7 + NSEG;
   localparam int P_TCK = PW - 1;
   localparam int P_SHF = PW - 2;
   localparam int P_EN  = PW - 3;
   localparam int P_SEN = PW - 4;
   localparam int P_SDR = PW - 5;
   localparam int P_INS = PW - 6;
   localparam int P_TDI = PW - 7;

   typedef struct packed {
      logic [PW-1:0]              s1;
      logic [PW-1:0]              s2;
      logic                       tck_d;
      logic                       shf_d;
      logic [1:0]                 clk_sel;
      logic                       ccm_mode;
      logic [NSEG-1:0][SL-1:0]    chain;
      logic                       tdo;
      logic                       rt_en;
      logic [31:0]                prdata;
   } ccm_state_t;

   ccm_state_t            r;
   ccm_state_t            next_r;
   logic [PW-1:0]         pins;
   logic                  tck_rise;
   logic                  shf_rise;
   logic                  ccm_sen;
   logic                  ccm_clk_en;
   logic                  ccm_shift;
   logic                  icl_shift;
   logic                  rt_en;
   logic                  d;
   logic [NSEG-1:0]       sib_v;
   logic [NSEG-1:0]       en_v;
   logic [NSEG-1:0]       cin_v;
   logic                  setup;
   logic                  access;
   logic                  hit_ctrl;
   logic                  hit_stat;
   ccm_src_t              eff_sel;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Every pin, tck included, passes s1 then s2; only s2 and later are read
   assign pins = {tck, shift_clock_src, ccm_en, scan_en, shift_dr, lbist_tap_instruction, tdi, ccm_scan_in};

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign setup    = apb_req.psel & ~apb_req.penable;
   assign access   = apb_req.psel & apb_req.penable;
   assign hit_ctrl = apb_req.paddr == `CCM_CTRL_OFS;
   assign hit_stat = apb_req.paddr == `CCM_STAT_OFS;
   // Zero wait states keep the tester flow simple
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = access & ~(hit_ctrl | hit_stat);
   assign apb_rsp.prdata  = r.prdata;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_r = r;
      d      = r.s2[P_TDI];
      next_r.s1    = pins;
      next_r.s2    = r.s1;
      next_r.tck_d = r.s2[P_TCK];
      next_r.shf_d = r.s2[P_SHF];
      tck_rise = r.s2[P_TCK] & ~r.tck_d;
      shf_rise = r.s2[P_SHF] & ~r.shf_d;

      // ----------------------------------------
      // Clock selection
      // ----------------------------------------
      // Chain mode forces tck
      if (r.ccm_mode) begin
         eff_sel = CCM_SRC_TCK;
      end else if (r.clk_sel == CCM_SRC_SHIFT) begin
         eff_sel = CCM_SRC_SHIFT;
      end else if (r.clk_sel == CCM_SRC_TCK) begin
         eff_sel = CCM_SRC_TCK;
      end else begin
         eff_sel = CCM_SRC_TEST;
      end
      case (eff_sel)
         CCM_SRC_SHIFT: begin
            rt_en = shf_rise;
         end
         CCM_SRC_TCK: begin
            rt_en = tck_rise;
         end
         default: begin
            rt_en = 1'b1;
         end
      endcase
      next_r.rt_en = rt_en;

      // ----------------------------------------
      // Chain and network
      // ----------------------------------------
      // Shift enable formed inside
      ccm_sen = r.s2[P_EN] & r.s2[P_SEN];
      ccm_clk_en = CCM_CLK_TCK ? tck_rise : 1'b1;
      ccm_shift  = ccm_sen & ccm_clk_en;
      // Network moves on tck edges only
      icl_shift  = ~ccm_sen & tck_rise & r.s2[P_SDR] & r.s2[P_INS];

      for (int i = 0; i < NSEG; i++) begin
         sib_v[i] = r.chain[i][SL-1];
      end
      // Top bit from instruction, child from parent
      en_v = {sib_v[NSEG-2:0], r.s2[P_INS]};
      // Joined chain feeds each segment from the previous one
      cin_v = SEG_PER_INSTR ? r.s2[NSEG-1:0] : {sib_v[NSEG-2:0], r.s2[0]};

      for (int i = 0; i < NSEG; i++) begin
         if (ccm_shift) begin
            // Network and outside flops shift as one path
            next_r.chain[i] = {r.chain[i][SL-2:0], cin_v[i]};
         end else begin
            // Functional flops keep their normal capture
            // Capture is held off while chain shift enable is set so a shift never meets a capture
            if (rt_en && !ccm_sen) begin
               next_r.chain[i][EXT_LEN-1:0] = func_d[i*EXT_LEN +: EXT_LEN];
            end
            if (icl_shift && en_v[i]) begin
               if (r.chain[i][SL-1]) begin
                  next_r.chain[i][SL-1:EXT_LEN] = {r.chain[i][SL-2:EXT_LEN], d};
               end else begin
                  next_r.chain[i][SL-1] = d;
               end
               d = r.chain[i][SL-1];
            end
         end
      end
      if (icl_shift) begin
         next_r.tdo = d;
      end

      // ----------------------------------------
      // Register file
      // ----------------------------------------
      if (setup) begin
         next_r.prdata = 32'h0000_0000;
         if (hit_ctrl) begin
            next_r.prdata[`CCM_SEL_LSB +: 2] = r.clk_sel;
            next_r.prdata[`CCM_MODE_BIT]     = r.ccm_mode;
         end else if (hit_stat) begin
            next_r.prdata[`CCM_SEL_LSB +: 2]          = eff_sel;
            next_r.prdata[`CCM_STAT_SEN_BIT]          = ccm_sen;
            next_r.prdata[`CCM_STAT_SIB_LSB +: NSEG]  = sib_v;
         end
      end
      if (access && apb_req.pwrite && hit_ctrl) begin
         next_r.clk_sel  = apb_req.pwdata[`CCM_SEL_LSB +: 2];
         next_r.ccm_mode = apb_req.pwdata[`CCM_MODE_BIT];
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         r         <= '0;
         r.clk_sel <= `CCM_SEL_RST;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign edt_lbist_clk_en = r.rt_en;
   assign tdo              = r.tdo;
   always_comb begin
      for (int i = 0; i < NSEG; i++) begin
         ccm_scan_out[i] = (SEG_PER_INSTR || i == NSEG - 1) ? r.chain[i][SL-1] : 1'b0;
         func_q[i*EXT_LEN +: EXT_LEN] = r.chain[i][EXT_LEN-1:0];
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_clk_default: assert property (@(posedge clk) srst |=> r.clk_sel == `CCM_SEL_RST && !r.ccm_mode)
      else $error("selector not on test clock after reset");
   a_ccm_tck_sel: assert property (@(posedge clk) disable iff (srst)
      r.ccm_mode |-> ##1 (edt_lbist_clk_en == $past(tck_rise)))
      else $error("runtime clock not following tck in chain mode");
   a_src_three: assert property (@(posedge clk) disable iff (srst)
      (!r.ccm_mode && r.clk_sel == CCM_SRC_SHIFT) |=> edt_lbist_clk_en == $past(shf_rise))
      else $error("shift clock source not selected");
   a_shift_path: assert property (@(posedge clk) disable iff (srst)
      ccm_shift |=> r.chain[0][0] == $past(cin_v[0]) && r.chain[0][SL-1] == $past(r.chain[0][SL-2]))
      else $error("chain did not shift as one path");
   a_shift_and: assert property (@(posedge clk) disable iff (srst)
      (!r.s2[P_EN] || !r.s2[P_SEN]) |=> r.chain[0][SL-1:EXT_LEN] == $past(r.chain[0][SL-1:EXT_LEN])
         || $past(icl_shift))
      else $error("chain moved without both enables");
   a_fixed_clk: assert property (@(posedge clk) disable iff (srst)
      (ccm_sen && CCM_CLK_TCK && !tck_rise) |=> $stable(r.chain))
      else $error("chain shifted off its build-time clock");
   a_bypass_reg: assert property (@(posedge clk) disable iff (srst)
      (icl_shift && !r.chain[0][SL-1]) |=> $stable(r.chain[0][SL-2:EXT_LEN]))
      else $error("bypassed register was shifted");
   a_sib_tck: assert property (@(posedge clk) disable iff (srst)
      (!tck_rise) |=> $stable(sib_v))
      else $error("insertion bit changed without tck edge");
   a_child_en: assert property (@(posedge clk) disable iff (srst)
      (icl_shift && !sib_v[0]) |=> $stable(r.chain[1][SL-1:EXT_LEN]))
      else $error("child shifted while parent clear");
   a_seg_join: assert property (@(posedge clk) disable iff (srst)
      (ccm_shift && !SEG_PER_INSTR) |=> r.chain[1][0] == $past(r.chain[0][SL-1]))
      else $error("segments not joined");
   a_seg_len: assert property (@(posedge clk)
      MAX_SEG_LEN == 0 || (MAX_SEG_LEN >= `CCM_MIN_SEG && SL <= MAX_SEG_LEN))
      else $error("segment length bound violated");
   a_idle_pass: assert property (@(posedge clk) disable iff (srst)
      (!ccm_sen && rt_en) |=> func_q == $past(func_d))
      else $error("functional capture disturbed with chain idle");
   // Tied-low chain enable leaves every segment stable in cycles with no network shift and no runtime clock
   a_tied_idle: assert property (@(posedge clk) disable iff (srst)
      (!r.s2[P_EN] && !icl_shift && !rt_en) |=> $stable(r.chain))
      else $error("chain moved with enable tied low");
   a_rt_test: assert property (@(posedge clk) disable iff (srst)
      (!r.ccm_mode && r.clk_sel != CCM_SRC_SHIFT && r.clk_sel != CCM_SRC_TCK) |=> edt_lbist_clk_en)
      else $error("test clock not running every cycle");
   a_tdo_hold: assert property (@(posedge clk) disable iff (srst)
      !icl_shift |=> $stable(tdo))
      else $error("network output moved without a tck shift");
   a_func_hold: assert property (@(posedge clk) disable iff (srst)
      (!ccm_shift && (ccm_sen || !rt_en)) |=> $stable(func_q))
      else $error("functional flops moved without a clock");
   a_scan_out_src: assert property (@(posedge clk) disable iff (srst)
      ccm_shift |=> ccm_scan_out[NSEG-1] == $past(r.chain[NSEG-1][SL-2]))
      else $error("last scan output not fed by its segment");
   a_ccm_no_net: assert property (@(posedge clk) disable iff (srst)
      ccm_sen |=> $stable(tdo))
      else $error("network moved during chain shift");
endmodule // ccm_ctrl_chain

/* File: sim/ccm_scan_tester.sv */
// Scan tester model facing the chain scan ports of the block
// Assumes the bench calls shift_bits just after a clk edge; tck rests low outside frames
`timescale 1ns/1ns
module ccm_scan_tester #(
   parameter int N = 3
) (
   // Clock
   input  wire logic         clk,
   // Chain scan link
   output logic             tck,
   output logic [N-1:0]     scan_in,
   input  wire logic [N-1:0] scan_out
);
   initial begin
      tck = 1'b0;
      scan_in = '0;
   end
   // ---------------------------------------------
   // One tck frame per bit, 8 clk period
   // ---------------------------------------------
   // bench sets the control register before frames; chain mode is on for only some of them
   task automatic shift_bits(input logic [N-1:0] din, output logic [N-1:0] dout);
      scan_in <= din;
      repeat (2) @(posedge clk);
      tck <= 1'b1;
      repeat (4) @(posedge clk);
      tck <= 1'b0;
      repeat (2) @(posedge clk);
      // Sampled late because the pins pass two sync stages
      dout = scan_out;
   endtask
endmodule // ccm_scan_tester

/* File: sim/controller_chain_scan_mode_tb.sv */
// Self-checking bench for the controller chain scan block
// Assumes the package, constants header and tester model compile first
`timescale 1ns/1ns
`include "ccm_consts.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module controller_chain_scan_mode_tb import ccm_pkg::*;;
   localparam int NSEG = 3;
   localparam int EXT = 2;
   localparam int SL = 5;
   logic                clk = 1'b0;
   logic                srst = 1'b1;
   logic                tck, clk_en, tdo, err;
   logic                shift_src = 1'b0;
   logic                instr = 1'b0;
   logic                sdr = 1'b0;
   logic                tdi = 1'b0;
   logic                ccm_en = 1'b0;
   logic                scan_en = 1'b0;
   logic [NSEG-1:0]     s_in, s_out, hold;
   logic [NSEG-1:0]     s_out2;
   ccm_apb_rsp_t        rsp2;
   logic [NSEG*EXT-1:0] func_d = '0;
   logic [NSEG*EXT-1:0] func_q;
   logic [31:0]         rd;
   ccm_apb_req_t        req = '0;
   ccm_apb_rsp_t        rsp;
   int                  bad_count = 0;
   int                  total_checks = 0;
   int                  pulses = 0;
   always #20 clk = ~clk;
   // Shift clock source runs slower than clk, period 10 clk
   always begin
      repeat (5) @(posedge clk);
      shift_src <= ~shift_src;
   end
   always @(posedge clk) if (clk_en === 1'b1) pulses <= pulses + 1;
   ccm_ctrl_chain #(.NSEG(NSEG), .DR_LEN(2), .EXT_LEN(EXT)) dut (.clk(clk), .srst(srst), .apb_req(req),
      .apb_rsp(rsp), .tck(tck), .shift_clock_src(shift_src), .edt_lbist_clk_en(clk_en),
      .lbist_tap_instruction(instr), .shift_dr(sdr), .tdi(tdi), .tdo(tdo), .ccm_en(ccm_en),
      .scan_en(scan_en), .ccm_scan_in(s_in), .ccm_scan_out(s_out), .func_d(func_d), .func_q(func_q));
   // Second copy built with one joined chain, fed the same stimulus
   ccm_ctrl_chain #(.NSEG(NSEG), .DR_LEN(2), .EXT_LEN(EXT), .SEG_PER_INSTR(1'b0)) dut_join (.clk(clk),
      .srst(srst), .apb_req(req), .apb_rsp(rsp2), .tck(tck), .shift_clock_src(shift_src), .edt_lbist_clk_en(),
      .lbist_tap_instruction(instr), .shift_dr(sdr), .tdi(tdi), .tdo(), .ccm_en(ccm_en),
      .scan_en(scan_en), .ccm_scan_in(s_in), .ccm_scan_out(s_out2), .func_d(func_d), .func_q());
   ccm_scan_tester #(.N(NSEG)) tester (.clk(clk), .tck(tck), .scan_in(s_in), .scan_out(s_out));
   // ---------------------------------------------
   // Bus and helper tasks
   // ---------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      // Waits as long as the slave asks; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask
   function automatic logic [2:0] pat(int k);
      return 3'(k * 5 + 3);
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_clock_select();
      logic [31:0] ctl [5] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0002, 32'h0000_0003, 32'h0000_0005};
      logic [1:0]  src [5] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h2};
      int          lo [5] = '{32, 2, 4, 32, 4};
      int          hi [5] = '{32, 4, 4, 32, 4};
      int          p0;
      apb(1'b0, `CCM_CTRL_OFS, 32'h0000_0000);
      `CHK("ctrl reset", 2'h1, rd[1:0])
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, `CCM_CTRL_OFS, ctl[i]);
         apb(1'b0, `CCM_STAT_OFS, 32'h0000_0000);
         `CHK("source", src[i], rd[1:0])
         repeat (6) @(posedge clk);
         #1 p0 = pulses;
         repeat (4) tester.shift_bits('0, hold);
         #1 `CHK("runtime clock pulses", 1'b1, (pulses - p0 >= lo[i] && pulses - p0 <= hi[i]))
      end
      apb(1'b1, 12'h008, 32'h0000_0007);
      `CHK("unmapped error", 1'b1, err)
      apb(1'b1, `CCM_STAT_OFS, 32'h0000_0000);
      apb(1'b0, `CCM_STAT_OFS, 32'h0000_0000);
      `CHK("status read only", 2'h2, rd[1:0])
   endtask
   task automatic t_enable_and();
      for (int i = 0; i < 4; i++) begin
         ccm_en <= i[0];
         scan_en <= i[1];
         repeat (5) @(posedge clk);
         apb(1'b0, `CCM_STAT_OFS, 32'h0000_0000);
         `CHK("chain shift enable", i[0] & i[1], rd[`CCM_STAT_SEN_BIT])
      end
      ccm_en <= 1'b0;
      scan_en <= 1'b0;
   endtask
   task automatic t_network();
      sdr <= 1'b1;
      tdi <= 1'b1;
      tester.shift_bits('0, hold);
      apb(1'b0, `CCM_STAT_OFS, 32'h0000_0000);
      `CHK("bits without instruction", 3'h0, rd[`CCM_STAT_SIB_LSB +: NSEG])
      instr <= 1'b1;
      repeat (4) @(posedge clk);
      tester.shift_bits('0, hold);
      apb(1'b0, `CCM_STAT_OFS, 32'h0000_0000);
      `CHK("first bit set", 3'h1, rd[`CCM_STAT_SIB_LSB +: NSEG])
      tester.shift_bits('0, hold);
      apb(1'b0, `CCM_STAT_OFS, 32'h0000_0000);
      `CHK("inserted bit shifts register", 3'h2, rd[`CCM_STAT_SIB_LSB +: NSEG])
      `CHK("network output", 1'b0, tdo)
      sdr <= 1'b0;
      instr <= 1'b0;
   endtask
   task automatic t_chain();
      logic [2:0] o;
      logic [2:0] p;
      // test clock back before the functional check
      apb(1'b1, `CCM_CTRL_OFS, 32'h0000_0001);
      func_d <= 6'h2d;
      repeat (6) @(posedge clk);
      `CHK("functional path", 6'h2d, func_q)
      // chain mode on before the segments are used
      apb(1'b1, `CCM_CTRL_OFS, 32'h0000_0005);
      ccm_en <= 1'b1;
      scan_en <= 1'b1;
      repeat (5) @(posedge clk);
      for (int k = 0; k < 4 * SL; k++) begin
         tester.shift_bits(pat(k), o);
         if (k >= SL - 1) `CHK("chain out", pat(k - SL + 1), o)
         if (k >= NSEG * SL - 1) begin
            p = pat(k - NSEG * SL + 1);
            `CHK("joined chain out", p[0], s_out2[NSEG-1])
            `CHK("joined side outputs", 2'h0, s_out2[NSEG-2:0])
         end
      end
      scan_en <= 1'b0;
      repeat (5) @(posedge clk);
      hold = s_out;
      repeat (3) tester.shift_bits(3'h7, o);
      `CHK("no shift when disabled", hold, o)
      ccm_en <= 1'b0;
      apb(1'b1, `CCM_CTRL_OFS, 32'h0000_0001);
      apb(1'b0, `CCM_CTRL_OFS, 32'h0000_0000);
      `CHK("mode restored", 1'b0, rd[`CCM_MODE_BIT])
   endtask
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_clock_select();
      t_enable_and();
      t_network();
      t_chain();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      summarize();
   end
endmodule // controller_chain_scan_mode_tb
